// ### src/wdg_supervisor.sv
// Watchdog timer with reset-source identification, a classic Wishbone slave.
// Assumes the CPU issues its protected instructions as command-register writes,
// and that the bus controller reports its cycle state on the same clock.
//
// Behaviour
// R1: Reset end loads control with 001c pin, 0004 software, 0006 watchdog.
// R2: End-of-init instruction clears control bits 4 down to 1.
// R3: After any reset the watchdog is enabled, counts from zero at clock/2; the code leaves it disabled after a pin reset into bootstrap mode.
// R4: Slow prescale select set makes the count input clock/128.
// R5: Disable works only until the first end-of-init or service instruction.
// R6: Counting continues during CPU idle unless disabled.
// R7: Passing the maximum unserviced overflows, starts internal reset, drives pin low.
// R8: Overflow sets overflow flag; pin reset or service clears it.
// R9: Before watchdog reset, finish or abort a running external bus cycle per ready.
// R10: Pin reset entering bootstrap mode leaves the watchdog disabled.
// R11: Service clears low count byte, loads high byte from reload field.
// R12: Malformed service instruction does nothing but raise the protection fault.
// R13: Service-to-overflow time is prescale times (65536 minus reload*256) clocks.
// R14: Control bit 5 stays reserved, no power-on flag.
// R15: Software should rewrite control before each service instruction.
// R16: Count is a 16-bit up counter of two 8-bit stages, readable.
// R17: Control upper byte holds the reload value for the high count byte.
// R18: Service in the same cycle as the final tick wins; no overflow.
//
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module wdg_supervisor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire wdg_pkg::wdg_wb_req_t wb_req_i,
  output var wdg_pkg::wdg_wb_rsp_t wb_rsp_o,
  input wire logic reset_input_pin_n_i,
  input wire logic boot_select_n_i,
  input wire logic ready_n_i,
  input wire logic bus_busy_i,
  input wire logic bus_uses_ready_i,
  input wire logic bus_wait_done_i,
  input wire logic cpu_idle_i,
  output logic reset_output_pin_n_o,
  output logic internal_reset_o,
  output logic bus_abort_o,
  output logic protection_fault_o
);
  import wdg_pkg::*;

  typedef struct packed {
    logic wb_ack;
    logic [31:0] wb_dat;
    logic [15:0] ctrl;
    logic [15:0] count;
    logic enabled;
    logic dis_ok;
    logic boot_mode;
    wdg_phase_t phase;
    wdg_src_t src;
    logic pin_m;
    logic pin_s;
    logic boot_m;
    logic boot_s;
    logic rdy_m;
    logic rdy_s;
    logic rst_out_n;
    logic int_rst;
    logic abort;
    logic fault;
    logic seq_start;
  } wdg_main_state_t;

  wdg_main_state_t s_reg;
  wdg_main_state_t s_next;

  logic tick;
  logic seq_active;
  logic seq_done;
  logic pre_clear;

  // Protected format: opcode in byte 0, its complement in byte 1
  function automatic logic cmd_is_protected(input logic [15:0] word);
    cmd_is_protected = (word[15:8] == ~word[7:0]);
  endfunction : cmd_is_protected

  // Control value after a reset, by source
  function automatic logic [15:0] src_value(input wdg_src_t src);
    unique case (src)
      SRC_PIN: src_value = CTL_PIN_RST;
      SRC_SOFT: src_value = CTL_SOFT_RST;
      SRC_WDT: src_value = CTL_WDT_RST;
      default: src_value = CTL_PIN_RST;
    endcase
  endfunction : src_value

  // Read mux; unmapped and write-only locations read zero
  function automatic logic [31:0] read_reg(input logic [31:0] adr,
                                           input wdg_main_state_t st);
    logic [31:0] val;
    val = 32'h0000_0000;
    if (adr[31:8] == 24'h000000) begin
      unique case (adr[7:0])
        OFS_CONTROL: val = {16'h0000, st.ctrl};
        OFS_COUNT: val = {16'h0000, st.count}; // see R16
        OFS_STATUS: begin
          val[STA_ENABLED] = st.enabled;
          val[STA_DIS_OK] = st.dis_ok;
          val[STA_IN_RESET] = (st.phase != PH_RUN);
          val[STA_BOOT] = st.boot_mode;
        end
        default: val = 32'h0000_0000;
      endcase
    end
    read_reg = val;
  endfunction : read_reg

  wdg_prescaler #(
    .DIV_F(DIV_FAST),
    .DIV_S(DIV_SLOW)
  ) u_prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(pre_clear),
    .slow_i(s_reg.ctrl[CTL_SLOW]), // see R4
    .tick_o(tick)
  );

  wdg_reset_seq #(
    .LEN(SEQ_CYCLES)
  ) u_reset_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(s_reg.seq_start),
    .hold_i(!s_reg.pin_s),
    .active_o(seq_active),
    .done_o(seq_done)
  );

  logic access;
  logic wr;
  logic map_hit;
  logic cmd_hit;
  logic cmd_ok;
  logic [7:0] opcode;
  logic run;
  logic service;
  logic end_init;
  logic disable_cmd;
  logic soft_reset;
  logic overflow;

  // Prescaler restarts on service so the period is exact
  assign pre_clear = service || (s_reg.phase != PH_RUN);

  always_comb begin
    s_next = s_reg;
    s_next.pin_m = reset_input_pin_n_i;
    s_next.pin_s = s_reg.pin_m;
    s_next.boot_m = boot_select_n_i;
    s_next.boot_s = s_reg.boot_m;
    s_next.rdy_m = ready_n_i;
    s_next.rdy_s = s_reg.rdy_m;
    s_next.wb_ack = 1'b0;
    s_next.abort = 1'b0;
    s_next.fault = 1'b0;
    s_next.seq_start = 1'b0;

    access = wb_req_i.cyc && wb_req_i.stb && !s_reg.wb_ack;
    wr = access && wb_req_i.we;
    map_hit = (wb_req_i.adr[31:8] == 24'h000000);
    run = (s_reg.phase == PH_RUN);
    cmd_hit = wr && map_hit && run && (wb_req_i.adr[7:0] == OFS_COMMAND)
              && wb_req_i.sel[0] && wb_req_i.sel[1];
    cmd_ok = cmd_hit && cmd_is_protected(wb_req_i.dat[15:0]);
    opcode = wb_req_i.dat[7:0];
    service = cmd_ok && (opcode == CMD_SERVICE);
    end_init = cmd_ok && (opcode == CMD_END_INIT);
    disable_cmd = cmd_ok && (opcode == CMD_DISABLE);
    soft_reset = cmd_ok && (opcode == CMD_SOFT_RESET);
    overflow = 1'b0;

    if (access) begin
      s_next.wb_ack = 1'b1;
      s_next.wb_dat = read_reg(wb_req_i.adr, s_reg);
    end

    // Bad encodings and unknown opcodes trap instead of acting
    if (cmd_hit && !cmd_ok) begin
      s_next.fault = 1'b1; // see R12
    end else if (cmd_ok && !(service || end_init || disable_cmd || soft_reset)) begin
      s_next.fault = 1'b1;
    end

    // Only reload and prescale select are writable; bit 5 stays zero
    if (wr && map_hit && run && (wb_req_i.adr[7:0] == OFS_CONTROL)) begin
      if (wb_req_i.sel[0]) begin
        s_next.ctrl[CTL_SLOW] = wb_req_i.dat[CTL_SLOW]; // see R4 R14
      end
      if (wb_req_i.sel[1]) begin
        s_next.ctrl[15:8] = wb_req_i.dat[15:8]; // see R17
      end
    end

    // Counts regardless of cpu_idle_i
    if (run && s_reg.enabled && tick && !service) begin // see R6
      if (s_reg.count == COUNT_MAX) begin
        overflow = 1'b1; // see R7
      end else begin
        s_next.count = s_reg.count + 16'h0001; // see R16
      end
    end

    if (service) begin
      // Service beats a coincident final tick
      s_next.count = {s_reg.ctrl[15:8], 8'h00}; // see R11 R13 R18
      s_next.ctrl[CTL_OVF] = 1'b0; // see R8
      s_next.dis_ok = 1'b0; // see R5
    end

    if (end_init) begin
      s_next.ctrl = s_reg.ctrl & ~CTL_EOI_CLEAR; // see R2
      s_next.dis_ok = 1'b0; // see R5
    end

    if (disable_cmd && s_reg.dis_ok) begin
      s_next.enabled = 1'b0; // see R5
    end

    if (soft_reset) begin
      s_next.phase = PH_SEQ;
      s_next.src = SRC_SOFT;
      s_next.seq_start = 1'b1;
      s_next.int_rst = 1'b1;
      s_next.rst_out_n = 1'b0;
    end

    if (overflow) begin
      s_next.ctrl[CTL_OVF] = 1'b1; // see R8
      s_next.phase = PH_DRAIN;
      s_next.src = SRC_WDT;
      s_next.rst_out_n = 1'b0; // see R7
    end

    // Overflow waits for the external bus cycle first
    if (s_reg.phase == PH_DRAIN) begin
      if (!bus_busy_i) begin
        s_next.phase = PH_SEQ; // see R9
        s_next.seq_start = 1'b1;
        s_next.int_rst = 1'b1;
      end else if (bus_wait_done_i && bus_uses_ready_i && s_reg.rdy_s) begin
        // Ready inactive after the wait states: abort the cycle
        s_next.abort = 1'b1; // see R9
        s_next.phase = PH_SEQ;
        s_next.seq_start = 1'b1;
        s_next.int_rst = 1'b1;
      end
    end

    if (s_reg.phase == PH_SEQ && seq_done) begin
      s_next.phase = PH_RUN;
      s_next.int_rst = 1'b0;
      s_next.rst_out_n = 1'b1;
      s_next.count = 16'h0000; // see R3
      s_next.ctrl = src_value(s_reg.src); // see R1 R3 R8 R14
      s_next.dis_ok = 1'b1;
      s_next.boot_mode = (s_reg.src == SRC_PIN) && !s_reg.boot_s;
      // Strap taken at the end of a pin reset
      s_next.enabled = !((s_reg.src == SRC_PIN) && !s_reg.boot_s); // see R3 R10
    end

    // Pin reset overrides every other source and phase
    if (!s_reg.pin_s && !(s_reg.phase == PH_SEQ && s_reg.src == SRC_PIN)) begin
      s_next.phase = PH_SEQ;
      s_next.src = SRC_PIN;
      s_next.seq_start = 1'b1;
      s_next.int_rst = 1'b1;
      s_next.rst_out_n = 1'b0;
      s_next.abort = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.ctrl <= CTL_PIN_RST;
      s_reg.enabled <= 1'b1;
      s_reg.dis_ok <= 1'b1;
      s_reg.phase <= PH_RUN;
      s_reg.src <= SRC_PIN;
      s_reg.pin_m <= 1'b1;
      s_reg.pin_s <= 1'b1;
      s_reg.boot_m <= 1'b1;
      s_reg.boot_s <= 1'b1;
      s_reg.rdy_m <= 1'b1;
      s_reg.rdy_s <= 1'b1;
      s_reg.rst_out_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_rsp_o.ack = s_reg.wb_ack;
  assign wb_rsp_o.dat = s_reg.wb_dat;
  assign reset_output_pin_n_o = s_reg.rst_out_n;
  assign internal_reset_o = s_reg.int_rst;
  assign bus_abort_o = s_reg.abort;
  assign protection_fault_o = s_reg.fault;

endmodule : wdg_supervisor
`default_nettype wire

// ### src/wdg_pkg.sv
// Constants, bus carriers and shared types of the watchdog reset supervisor.
// Assumes a 32-bit classic Wishbone register bus and one 100 MHz clock.
package wdg_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_COMMAND = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;

  // Control register fields
  localparam int unsigned CTL_SLOW = 0;
  localparam int unsigned CTL_OVF = 1;
  localparam int unsigned CTL_SOFT = 2;
  localparam int unsigned CTL_SHORT = 3;
  localparam int unsigned CTL_LONG = 4;
  localparam int unsigned CTL_RELOAD_LSB = 8;
  localparam logic [15:0] CTL_PIN_RST = 16'h001c;
  localparam logic [15:0] CTL_SOFT_RST = 16'h0004;
  localparam logic [15:0] CTL_WDT_RST = 16'h0006;
  localparam logic [15:0] CTL_EOI_CLEAR = 16'h001e;

  // Status register fields
  localparam int unsigned STA_ENABLED = 0;
  localparam int unsigned STA_DIS_OK = 1;
  localparam int unsigned STA_IN_RESET = 2;
  localparam int unsigned STA_BOOT = 3;

  // Command opcodes (values arbitrary); byte 1 must hold the complement
  localparam logic [7:0] CMD_SERVICE = 8'h1e;
  localparam logic [7:0] CMD_DISABLE = 8'h2d;
  localparam logic [7:0] CMD_END_INIT = 8'h3c;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h4b;

  // Timing counts
  localparam int unsigned DIV_FAST = 2;
  localparam int unsigned DIV_SLOW = 128;
  localparam int unsigned SEQ_CYCLES = 516;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [31:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wdg_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wdg_wb_rsp_t;

  typedef enum logic [1:0] {PH_RUN, PH_DRAIN, PH_SEQ} wdg_phase_t;
  typedef enum logic [1:0] {SRC_PIN, SRC_SOFT, SRC_WDT} wdg_src_t;

endpackage : wdg_pkg

// ### src/wdg_prescaler.sv
// Count-input prescaler: one tick per 2 or per 128 clock cycles.
// Assumes clear is a same-domain level from the supervisor.
`timescale 1ns/1ns
`default_nettype none
module wdg_prescaler #(
  parameter int unsigned DIV_F = wdg_pkg::DIV_FAST,
  parameter int unsigned DIV_S = wdg_pkg::DIV_SLOW
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic slow_i,
  output logic tick_o
);
  import wdg_pkg::*;

  typedef struct packed {
    logic [6:0] cnt;
    logic tick;
  } wdg_pre_state_t;

  wdg_pre_state_t s_reg;
  wdg_pre_state_t s_next;
  logic [6:0] last;

  always_comb begin
    s_next = s_reg;
    last = slow_i ? 7'(DIV_S - 1) : 7'(DIV_F - 1);
    s_next.tick = 1'b0;
    if (clear_i) begin
      s_next.cnt = 7'h00;
    end else if (s_reg.cnt >= last) begin
      // Compare with >= so a mid-count switch to fast never stalls
      s_next.cnt = 7'h00;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 7'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick_o = s_reg.tick;
endmodule : wdg_prescaler
`default_nettype wire

// ### src/wdg_reset_seq.sv
// Internal reset sequence timer: fixed length, then held while the pin is low.
// Assumes start and hold are same-domain levels; start restarts the count.
`timescale 1ns/1ns
`default_nettype none
module wdg_reset_seq #(
  parameter int unsigned LEN = wdg_pkg::SEQ_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic hold_i,
  output logic active_o,
  output logic done_o
);
  import wdg_pkg::*;

  typedef struct packed {
    logic [9:0] cnt;
    logic active;
    logic done;
  } wdg_seq_state_t;

  wdg_seq_state_t s_reg;
  wdg_seq_state_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (start_i) begin
      s_next.active = 1'b1;
      s_next.cnt = 10'h000;
    end else if (s_reg.active) begin
      if (s_reg.cnt < 10'(LEN - 1)) begin
        s_next.cnt = s_reg.cnt + 10'h001;
      end else if (!hold_i) begin
        s_next.active = 1'b0;
        s_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign active_o = s_reg.active;
  assign done_o = s_reg.done;
endmodule : wdg_reset_seq
`default_nettype wire

// ### tb/wdg_chk.sv
// Checker: bus handshake, traps and reset pin timing of the supervisor.
// Assumes it is bound to wdg_supervisor and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module wdg_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire wdg_pkg::wdg_wb_req_t wb_req_i,
  input wire wdg_pkg::wdg_wb_rsp_t wb_rsp_o,
  input wire logic reset_input_pin_n_i,
  input wire logic bus_busy_i,
  input wire logic bus_uses_ready_i,
  input wire logic bus_wait_done_i,
  input wire logic reset_output_pin_n_o,
  input wire logic internal_reset_o,
  input wire logic bus_abort_o,
  input wire logic protection_fault_o
);
  import wdg_pkg::*;
  logic [10:0] len_reg;
  // Saturates so a pin held low for long cannot wrap the count
  always_ff @(posedge clk_i) begin
    if (rst_i || !internal_reset_o) begin
      len_reg <= '0;
    end else if (len_reg != 11'h7ff) begin
      len_reg <= len_reg + 11'h1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_one_cycle_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
    else $error("request not answered next cycle");
  fault_on_cmd_a: assert property (protection_fault_o |-> wb_rsp_o.ack && $past(wb_req_i.we)
    && $past(wb_req_i.adr) == 32'h8) else $error("fault without command write");
  abort_cause_a: assert property (bus_abort_o |-> !reset_output_pin_n_o
    && $past(bus_busy_i && bus_uses_ready_i && bus_wait_done_i)) else $error("abort without cause");
  abort_one_a: assert property (bus_abort_o |=> !bus_abort_o)
    else $error("abort longer than one cycle");
  pin_low_seq_a: assert property (internal_reset_o |-> !reset_output_pin_n_o)
    else $error("reset out high during internal reset");
  seq_length_a: assert property ($fell(internal_reset_o) |-> len_reg >= 11'h203)
    else $error("internal reset too short");
  pin_extend_a: assert property (!reset_input_pin_n_i [*6] |-> internal_reset_o)
    else $error("pin low without internal reset");
  cover property ($rose(internal_reset_o));
  cover property (protection_fault_o);
  cover property (bus_abort_o);
endmodule : wdg_chk
bind wdg_supervisor wdg_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
  .reset_input_pin_n_i(reset_input_pin_n_i), .bus_busy_i(bus_busy_i), .bus_uses_ready_i(bus_uses_ready_i),
  .bus_wait_done_i(bus_wait_done_i), .reset_output_pin_n_o(reset_output_pin_n_o),
  .internal_reset_o(internal_reset_o), .bus_abort_o(bus_abort_o), .protection_fault_o(protection_fault_o));
`default_nettype wire

// ### tb/wdg_cpu_model.sv
// CPU core model: issues protected instructions as Wishbone command writes.
// Assumes the supervisor acks every access; the bench watchdog ends a hang.
`timescale 1ns/1ns
`default_nettype none
module wdg_cpu_model (
  input wire logic clk_i,
  input wire wdg_pkg::wdg_wb_rsp_t wb_rsp_i,
  output var wdg_pkg::wdg_wb_req_t wb_req_o
);
  import wdg_pkg::*;
  initial wb_req_o = '0;
  task automatic xfer(input logic [7:0] a, input logic w, input logic [15:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_req_o <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {24'h0, a}, sel: 4'h3, dat: {16'h0, d}};
    do begin
      @(posedge clk_i);
    end while (wb_rsp_i.ack !== 1'b1);
    q = wb_rsp_i.dat;
    wb_req_o <= '0;
  endtask : xfer
  // Bad encoding repeats the opcode instead of its complement
  task automatic cmd(input logic [7:0] op, input logic good);
    logic [31:0] q;
    xfer(OFS_COMMAND, 1'b1, {good ? ~op : op, op}, q);
  endtask : cmd
  task automatic service(input logic [15:0] ctl);
    logic [31:0] q;
    xfer(OFS_CONTROL, 1'b1, ctl, q);
    cmd(CMD_SERVICE, 1'b1);
  endtask : service
endmodule : wdg_cpu_model
`default_nettype wire

// ### tb/tb.sv
// Bench: register table, instructions, overflow with drain, reset sources.
// Assumes the CPU model drives the bus; pins and external bus come from here.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import wdg_pkg::*;
  typedef struct packed {logic [7:0] a; logic w; logic [15:0] d; logic [15:0] e;} wdg_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic pin_n = 1'b1;
  logic boot_n = 1'b1;
  logic rdy_n = 1'b1;
  logic busy = 1'b0;
  logic uses = 1'b0;
  logic wdone = 1'b0;
  logic idle = 1'b0;
  logic pin_out_n, in_rst, abt, flt;
  wdg_wb_req_t req;
  wdg_wb_rsp_t rsp;
  logic [31:0] q, v;
  int n_fail = 0;
  int checks = 0;
  int n_abt = 0;
  int n_flt = 0;
  int n;
  wdg_row_t rows [10] = '{
    '{8'h00, 1'b0, 16'h0, 16'h001c},
    '{8'h0c, 1'b0, 16'h0, 16'h0003},
    '{8'h00, 1'b1, 16'h01ff, 16'h0},
    '{8'h00, 1'b0, 16'h0, 16'h011d},
    '{8'h08, 1'b1, 16'hc33c, 16'h0},
    '{8'h00, 1'b0, 16'h0, 16'h0101},
    '{8'h08, 1'b1, 16'hd22d, 16'h0},
    '{8'h0c, 1'b0, 16'h0, 16'h0001},
    '{8'h44, 1'b0, 16'h0, 16'h0},
    '{8'h08, 1'b0, 16'h0, 16'h0}};
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (abt === 1'b1) n_abt++;
    if (flt === 1'b1) n_flt++;
  end
  wdg_cpu_model i_cpu (.clk_i(clk_i), .wb_rsp_i(rsp), .wb_req_o(req));
  wdg_supervisor i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
    .reset_input_pin_n_i(pin_n), .boot_select_n_i(boot_n), .ready_n_i(rdy_n), .bus_busy_i(busy),
    .bus_uses_ready_i(uses), .bus_wait_done_i(wdone), .cpu_idle_i(idle), .reset_output_pin_n_o(pin_out_n),
    .internal_reset_o(in_rst), .bus_abort_o(abt), .protection_fault_o(flt));
  task automatic results();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    i_cpu.xfer(a, 1'b0, 16'h0, q);
    cmp(q, {16'h0, e});
  endtask : rd
  // Waits for a sequence to start, then to end; the watchdog catches a hang
  task automatic seq_wait();
    while (in_rst !== 1'b1) begin
      @(posedge clk_i);
    end
    while (in_rst !== 1'b0) begin
      @(posedge clk_i);
    end
  endtask : seq_wait
  initial begin
    #200000;
    n_fail++;
    results();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      i_cpu.xfer(rows[i].a, rows[i].w, rows[i].d, q);
      if (!rows[i].w) cmp(q, {16'h0, rows[i].e});
    end
    $display("test 0 done");
    idle <= 1'b1;
    busy <= 1'b1;
    uses <= 1'b1;
    wdone <= 1'b1;
    i_cpu.service(16'hff00);
    i_cpu.xfer(OFS_COUNT, 1'b0, 16'h0, q);
    cmp(q & 32'hfffffffc, 32'hff00);
    n = 0;
    while (pin_out_n !== 1'b0 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    cmp(32'(n >= 500 && n <= 515), 32'h1);
    seq_wait();
    busy <= 1'b0;
    cmp(32'(n_abt), 32'h1);
    rd(OFS_CONTROL, CTL_WDT_RST);
    i_cpu.xfer(OFS_COUNT, 1'b0, 16'h0, q);
    cmp(q & 32'hfffffff0, 32'h0);
    $display("test 1 done");
    i_cpu.service(16'h0000);
    rd(OFS_CONTROL, 16'h0004);
    i_cpu.cmd(CMD_SERVICE, 1'b0);
    // Let the pulse counter see this edge before comparing
    @(posedge clk_i);
    cmp(32'(n_flt), 32'h1);
    $display("test 2 done");
    i_cpu.cmd(CMD_SOFT_RESET, 1'b1);
    seq_wait();
    rd(OFS_CONTROL, CTL_SOFT_RST);
    i_cpu.cmd(CMD_DISABLE, 1'b1);
    i_cpu.xfer(OFS_STATUS, 1'b0, 16'h0, q);
    cmp(q & 32'h9, 32'h0);
    i_cpu.xfer(OFS_COUNT, 1'b0, 16'h0, v);
    repeat (20) @(posedge clk_i);
    i_cpu.xfer(OFS_COUNT, 1'b0, 16'h0, q);
    cmp(q, v);
    $display("test 3 done");
    boot_n <= 1'b0;
    pin_n <= 1'b0;
    repeat (12) @(posedge clk_i);
    pin_n <= 1'b1;
    seq_wait();
    i_cpu.xfer(OFS_STATUS, 1'b0, 16'h0, q);
    cmp(q & 32'h9, 32'h8);
    rd(OFS_CONTROL, CTL_PIN_RST);
    boot_n <= 1'b1;
    $display("test 4 done");
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_CONTROL, CTL_PIN_RST);
    rd(OFS_STATUS, 16'h0003);
    $display("test 5 done");
    results();
  end
endmodule : tb
`default_nettype wire
